// File: bench/chfd_props.sv
`timescale 1ns/1ps
`include "chfd_defs.vh"
// watch on dma framing and pin enable
module chfd_props (
	// clock and reset
	input wire        hclk,
	input wire        hresetn,
	// register bus
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [31:0] hwdata,
	input wire        hready,
	// serial pin and dma port
	input wire        serial_tx_data_oe,
	input wire        dma_req,
	input wire        dma_gnt,
	input wire [1:0]  dma_kind,
	input wire        dma_dir_rx,
	input wire [5:0]  dma_len,
	input wire        dma_rready,
	input wire        dma_wvalid
);
	reg       wp_ff;   // control write now in data phase
	reg       txen_ff; // shadow of transmit enable
	reg       tri_ff;  // shadow of unmapped tristate
	reg [4:0] on_ff;   // cycles enabled with tristate off
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// control is not a port: shadow it
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp_ff   <= 1'h0;
			txen_ff <= 1'h0;
			tri_ff  <= 1'h0;
			on_ff   <= 5'h00;
		end else begin
			wp_ff <= hsel && htrans[1] && hready && hwrite && haddr[11:0] == `CHFD_CTRL_OFF;
			if (wp_ff) begin
				txen_ff <= hwdata[`CHFD_CTRL_TXEN];
				tri_ff  <= hwdata[`CHFD_CTRL_TRI];
			end
			// saturates: bounds the bit event wait
			if (txen_ff && !tri_ff)
				on_ff <= on_ff + {4'h0, on_ff != 5'h1F};
			else
				on_ff <= 5'h00;
		end
	end
	sequence s_off2;
		!txen_ff [*2];
	endsequence
	sequence s_pre_grant;
		dma_req && !dma_gnt && !$past(dma_gnt);
	endsequence
	a_len_cap: assert property (dma_req |-> dma_len != 6'h00 && dma_len <= 6'h20)
		else $error("burst length out of range");
	a_desc_single: assert property (
		dma_req && dma_kind == `CHFD_KIND_DESC |-> dma_len == 6'h01)
		else $error("descriptor longer than one dword");
	a_job_stable: assert property (
		dma_req && $past(dma_req) |-> $stable(dma_kind) && $stable(dma_len))
		else $error("burst changed while requested");
	a_write_rx_only: assert property (dma_wvalid |->
		dma_req && dma_dir_rx && dma_kind == `CHFD_KIND_RXWR)
		else $error("write beat outside a receive flush");
	a_read_not_rx: assert property (
		dma_rready |-> dma_req && dma_kind != `CHFD_KIND_RXWR)
		else $error("read beat outside a read job");
	a_beat_after_grant: assert property (s_pre_grant |-> !dma_rready && !dma_wvalid)
		else $error("beat before grant");
	a_off_hiz: assert property (s_off2 |-> !serial_tx_data_oe)
		else $error("pin driven while transmitter off");
	a_no_tri_drive: assert property (on_ff == 5'h1F |-> serial_tx_data_oe)
		else $error("pin floats with tristate setting off");
endmodule // chfd_props

bind chfd_top chfd_props u_props (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.serial_tx_data_oe(serial_tx_data_oe), .dma_req(dma_req), .dma_gnt(dma_gnt),
	.dma_kind(dma_kind), .dma_dir_rx(dma_dir_rx), .dma_len(dma_len),
	.dma_rready(dma_rready), .dma_wvalid(dma_wvalid)
);

// File: bench/chfd_shmem.sv
`timescale 1ns/1ps
`include "chfd_defs.vh"
// shared memory; bursts alternate prompt and slow
module chfd_shmem #(
	parameter [31:0] D0 = 32'hFFFF_FFFE,
	parameter [31:0] D1 = 32'hA5C3_0F12
) (
	// clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// burst port
	input  wire        dma_req,
	output reg         dma_gnt,
	input  wire [1:0]  dma_kind,
	output wire        dma_rvalid,
	output wire [31:0] dma_rdata,
	input  wire        dma_rready,
	output wire        dma_wready
);
	reg [1:0] wt_ff;   // cycles waited for grant
	reg [5:0] bt_ff;   // read beats of this burst
	reg       slow_ff; // slow burst stalls every other cycle
	reg       cyc_ff;  // cycle toggle
	wire      stall = slow_ff && cyc_ff;
	wire      own   = dma_gnt && dma_req;
	// beats only in a granted burst
	assign dma_rvalid = own && dma_kind != `CHFD_KIND_RXWR && !stall;
	assign dma_wready = own && dma_kind == `CHFD_KIND_RXWR && !stall;
	// idle data toggles so stale data never passes
	assign dma_rdata = dma_rvalid ? (bt_ff == 6'h00 ? D0 : D1) : {16{cyc_ff, !cyc_ff}};
	// grant after a short or long wait, held until release
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dma_gnt <= 1'h0;
			wt_ff   <= 2'h0;
			bt_ff   <= 6'h00;
			slow_ff <= 1'h0;
			cyc_ff  <= 1'h0;
		end else begin
			cyc_ff <= !cyc_ff;
			if (!dma_req) begin
				dma_gnt <= 1'h0;
				wt_ff   <= 2'h0;
				bt_ff   <= 6'h00;
			end else begin
				if (!dma_gnt)
					wt_ff <= wt_ff + 2'h1;
				if (!dma_gnt && wt_ff == {slow_ff, 1'h1}) begin
					dma_gnt <= 1'h1;
					slow_ff <= !slow_ff;
				end
				if (dma_rvalid && dma_rready)
					bt_ff <= bt_ff + 6'h01;
			end
		end
	end
endmodule // chfd_shmem

// File: bench/testbench.sv
`timescale 1ns/1ps
`include "chfd_defs.vh"
// bus master, link clock, memory model
module testbench;
	localparam [31:0] D0 = 32'hFFFF_FFFE; // first dword of each burst
	localparam [31:0] D1 = 32'hA5C3_0F12; // later dwords
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, dma_rdata, dma_wdata, wdat, rd;
	logic [1:0]  htrans, dma_kind;
	logic [2:0]  hsize;
	logic        bclk, rxd, txd, txoe, rq_q, wseen;
	logic        dma_req, dma_gnt, dma_dir_rx, dma_rvalid, dma_rready, dma_wvalid, dma_wready;
	logic [4:0]  dma_chan, mon_ch;
	logic [5:0]  dma_len;
	logic [7:0]  jobs[$]; // kind, length per burst
	int          bad_count, num_checks;
	assign hready = hreadyout;
	always #2 hclk = ~hclk;
	// link clock, phase unrelated to hclk
	initial begin
		bclk = 1'h0;
		#5;
		forever #32 bclk = ~bclk;
	end
	chfd_top u_chfd_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serial_tx_bit_clock(bclk),
		.serial_rx_data_in(rxd), .serial_tx_data_out(txd), .serial_tx_data_oe(txoe),
		.dma_req(dma_req), .dma_gnt(dma_gnt), .dma_kind(dma_kind), .dma_dir_rx(dma_dir_rx),
		.dma_chan(dma_chan), .dma_len(dma_len), .dma_rvalid(dma_rvalid),
		.dma_rdata(dma_rdata), .dma_rready(dma_rready), .dma_wvalid(dma_wvalid),
		.dma_wdata(dma_wdata), .dma_wready(dma_wready));
	chfd_shmem #(.D0(D0), .D1(D1)) u_chfd_shmem (.hclk(hclk), .hresetn(hresetn),
		.dma_req(dma_req), .dma_gnt(dma_gnt), .dma_kind(dma_kind), .dma_rvalid(dma_rvalid),
		.dma_rdata(dma_rdata), .dma_rready(dma_rready), .dma_wready(dma_wready));
	// log new bursts of mon_ch, first write beat
	always @(posedge hclk) begin
		rq_q <= dma_req;
		if (dma_req && !rq_q && dma_chan == mon_ch)
			jobs.push_back({dma_kind, dma_len});
		if (dma_wvalid && dma_wready && !wseen) begin
			wseen <= 1'h1;
			wdat  <= dma_wdata;
		end
	end
	task chk(input logic [63:0] s, e, input string n);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("Error %s: expected %h, seen %h", n, e, s);
		end
	endtask
	task report_and_stop;
		$display("checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// one word; read data taken at the data phase edge
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {20'h00000, a};
		do @(posedge hclk); while (hready !== 1'h1);
		hsel   <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'h1);
		rd = hrdata;
	endtask
	// control write, then a few bit events
	task ctrl(input logic [31:0] v);
		xfer(1'h1, `CHFD_CTRL_OFF, v);
		repeat (3) @(negedge bclk);
	endtask
	task map_all(input logic [31:0] v);
		for (int i = 0; i < 32; i++) xfer(1'h1, 12'h200 + 12'(4 * i), v);
	endtask
	task wait_jobs(input int n);
		for (int i = 0; i < 20000 && jobs.size() < n; i++) @(posedge hclk);
	endtask
	task t_pool;
		xfer(1'h0, `CHFD_STAT_OFF, 32'h0);
		chk(rd[7:0], `CHFD_POOL_FIXED, "pool fixed");
		chk({hreadyout, hresp}, 2'h2, "bus response");
		xfer(1'h1, `CHFD_CTRL_OFF, 32'h8);
		xfer(1'h0, `CHFD_STAT_OFF, 32'h0);
		chk(rd[7:0], `CHFD_POOL_FULL, "pool full");
		xfer(1'h0, 12'hFFC, 32'h0);
		chk(rd, 32'h0, "unmapped read");
	endtask
	// output modes: off, mapped idle, unmapped
	task t_modes;
		map_all(32'h81);
		ctrl(32'h2);
		chk(txoe, 1'h0, "oe disabled");
		ctrl(32'h1);
		chk({txoe, txd}, 2'h3, "mapped idle");
		map_all(32'h0);
		ctrl(32'h3);
		chk(txoe, 1'h0, "unmapped float");
		ctrl(32'h1);
		chk({txoe, txd}, 2'h3, "unmapped one");
	endtask
	// descriptor, fill, then lsb-first data on falling edge
	task t_tx;
		logic [63:0] s;
		int i;
		xfer(1'h1, 12'h104, 32'h0008_0104);
		map_all(32'h81);
		ctrl(32'h5);
		mon_ch = 5'h01;
		jobs.delete();
		xfer(1'h1, `CHFD_SRQ_OFF, 32'h0000_0101);
		wait_jobs(2);
		chk(jobs[0], {`CHFD_KIND_DESC, 6'h01}, "tx first job");
		chk(jobs[1], {`CHFD_KIND_TXRD, 6'h02}, "tx fill job");
		i = 0;
		do begin @(posedge bclk); i++; end while (txd !== 1'h0 && i < 4000);
		s[0] = txd;
		for (i = 1; i < 64; i++) begin @(posedge bclk); s[i] = txd; end
		chk(s, {D1, D0}, "tx stream");
	endtask
	// receive: descriptor, then one-dword flush
	task t_rx;
		int di, ri;
		di = -1;
		ri = -1;
		jobs.delete();
		wseen = 1'h0;
		xfer(1'h1, `CHFD_SRQ_OFF, 32'h0000_0201);
		for (int i = 0; i < 20000 && !wseen; i++) @(posedge hclk);
		foreach (jobs[k]) begin
			if (di < 0 && jobs[k][7:6] == `CHFD_KIND_DESC) di = k;
			if (ri < 0 && jobs[k][7:6] == `CHFD_KIND_RXWR) ri = k;
		end
		chk(di >= 0 && di < ri, 1'h1, "rx order");
		chk(ri < 0 ? 8'h00 : jobs[ri], {`CHFD_KIND_RXWR, 6'h01}, "rx flush");
		chk(wdat, 32'hFFFF_FFFF, "rx data");
	endtask
	// a 40 dword half splits into 32 and 8
	task t_cap;
		ctrl(32'hD);
		xfer(1'h1, 12'h108, 32'h0000_2710);
		mon_ch = 5'h02;
		jobs.delete();
		xfer(1'h1, `CHFD_SRQ_OFF, 32'h0000_0102);
		wait_jobs(3);
		chk(jobs[1], {`CHFD_KIND_TXRD, 6'h20}, "capped burst");
		chk(jobs[2], {`CHFD_KIND_TXRD, 6'h08}, "rest burst");
	endtask
	initial begin
		{hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata, rq_q, wseen} = '0;
		hsize = 3'h2;
		rxd = 1'h1;
		mon_ch = 5'h00;
		repeat (12) @(posedge hclk);
		hresetn <= 1'h1;
		t_pool;
		t_modes;
		t_tx;
		t_rx;
		t_cap;
		report_and_stop;
	end
	// watchdog
	initial begin
		#200000;
		bad_count++;
		report_and_stop;
	end
endmodule // testbench

// File: inc/chfd_defs.vh
`ifndef CHFD_DEFS_VH
`define CHFD_DEFS_VH
// register byte offsets
`define CHFD_CTRL_OFF    12'h000
`define CHFD_SRQ_OFF     12'h004
`define CHFD_TXACT_OFF   12'h008
`define CHFD_RXACT_OFF   12'h00C
`define CHFD_STAT_OFF    12'h010
// windows in bits 11:8, index in bits 6:2
`define CHFD_CHCFG_WIN   4'h1
`define CHFD_SLOT_WIN    4'h2
// control register fields
`define CHFD_CTRL_TXEN   0
`define CHFD_CTRL_TRI    1
`define CHFD_CTRL_EDGE   2
`define CHFD_CTRL_SUBDIS 3
`define CHFD_CTRL_RST    4'h0
// service request fields and opcodes
`define CHFD_SRQ_OP_LSB  8
`define CHFD_OP_ACT_TX   2'h1
`define CHFD_OP_ACT_RX   2'h2
`define CHFD_OP_DEACT    2'h3
// channel config fields (lsb positions)
`define CHFD_CFG_TXOFF   0
`define CHFD_CFG_TXLEN   8
`define CHFD_CFG_RXOFF   16
`define CHFD_CFG_RXLEN   24
// slot map fields
`define CHFD_SLOT_MAPPED 7
// buffer pools in dwords
`define CHFD_POOL_FIXED  8'h40
`define CHFD_POOL_FULL   8'h80
// longest burst in dwords
`define CHFD_BURST_CAP   7'h20
// dma job kinds
`define CHFD_KIND_TXRD   2'h0
`define CHFD_KIND_RXWR   2'h1
`define CHFD_KIND_DESC   2'h2
// serial output modes
`define CHFD_TXM_Z       2'h0
`define CHFD_TXM_ONE     2'h1
`define CHFD_TXM_DATA    2'h2
`endif

// File: src/chfd_mem.v
`timescale 1ns/1ps
// buffer ram, registered read data
module chfd_mem #(
	parameter DW    = 32,
	parameter DEPTH = 128,
	parameter AW    = 7
) (
	// clock and reset
	input  wire          hclk,
	input  wire          hresetn,
	// access port
	input  wire          en,
	input  wire          we,
	input  wire [AW-1:0] addr,
	input  wire [DW-1:0] wdata,
	output reg  [DW-1:0] rdata
);
	reg [DW-1:0] mem [0:DEPTH-1]; // storage, no reset

	// write side
	always @(posedge hclk) begin
		if (en && we)
			mem[addr] <= wdata;
	end

	// read register only moves on a read, so a write never disturbs it
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rdata <= {DW{1'b0}};
		else if (en && !we)
			rdata <= mem[addr];
	end
endmodule // chfd_mem

// File: src/chfd_top.v
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "chfd_defs.vh"
// Function
// - subchannels in use: 64-dword pool only
// - subchannels disabled: 128-dword pool
// - buffer start is dword offset in pool
// - burst is length plus one, max 32
// - receive activation fetches descriptor first
// - receive fills half at start offset
// - full receive half flushed, other half fills
// - receive flush: request bus, write, release
// - transmit activation fetches descriptor first
// - transmit activation starts fetch at once
// - fetched data fills half, other half sends
// - transmit fill: request bus, read, release
// - new output bit each selected clock edge
// - transmitter disabled: output high impedance
// - mapped activated slot sends channel data
// - mapped inactive slot sends logic one
// - unmapped slot: tristate or one by setting
// - half size is length field plus one
// - subchannel disable bit selects pool size
module chfd_top #(
	parameter NCH   = 32,
	parameter CW    = 5,
	parameter NSLOT = 32,
	parameter SW    = 5
) (
	// clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	// serial line
	input  wire        serial_tx_bit_clock,
	input  wire        serial_rx_data_in,
	output reg         serial_tx_data_out,
	output reg         serial_tx_data_oe,
	// dma master toward shared memory
	output wire        dma_req,
	input  wire        dma_gnt,
	output reg  [1:0]  dma_kind,
	output reg         dma_dir_rx,
	output reg  [CW-1:0] dma_chan,
	output reg  [5:0]  dma_len,
	input  wire        dma_rvalid,
	input  wire [31:0] dma_rdata,
	output wire        dma_rready,
	output wire        dma_wvalid,
	output wire [31:0] dma_wdata,
	input  wire        dma_wready
);
	localparam D_IDLE = 3'h0, D_REQ = 3'h1, D_TXB = 3'h2, D_RXRD = 3'h3;
	localparam D_RXW  = 3'h4, D_GAP = 3'h5;

	// pool address of a dword, wrapped to the pool
	function [6:0] faddr;
		input [6:0] start;
		input       half;
		input [5:0] hl;
		input [6:0] idx;
		input       subdis;
		reg   [7:0] sum;
		begin
			sum = {1'b0, start} + {1'b0, idx} + (half ? ({2'h0, hl} + 8'h01) : 8'h00);
			faddr = subdis ? sum[6:0] : {1'b0, sum[5:0]};
		end
	endfunction

	// one burst: remaining dwords, capped
	function [5:0] fburst;
		input [6:0] left;
		begin
			fburst = (left > `CHFD_BURST_CAP) ? 6'h20 : left[5:0];
		end
	endfunction

	// software-visible configuration
	reg  [3:0]    ctrl_ff;                 // enable, tristate, edge, subchannel disable
	reg  [6:0]    tx_off_ff [0:NCH-1];     // buffer_start_offset, transmit
	reg  [5:0]    tx_hl_ff  [0:NCH-1];     // half_buffer_length, transmit
	reg  [6:0]    rx_off_ff [0:NCH-1];     // buffer_start_offset, receive
	reg  [5:0]    rx_hl_ff  [0:NCH-1];     // half_buffer_length, receive
	reg  [7:0]    slot_ff   [0:NSLOT-1];   // mapped flag and channel per slot
	// bus pipeline
	reg           a_en_ff;                 // data phase pending
	reg           a_wr_ff;                 // pending phase is a write
	reg  [11:0]   a_addr_ff;               // latched address
	reg  [31:0]   rd_mux;                  // read value for address phase
	// per-channel engine state
	reg  [NCH-1:0] tx_act_ff, rx_act_ff;   // activate request seen
	reg  [NCH-1:0] tx_desc_ff, rx_desc_ff; // descriptor fetch outstanding
	reg  [1:0]    tx_need_ff [0:NCH-1];    // transmit half awaits fill
	reg  [1:0]    rx_full_ff [0:NCH-1];    // receive half awaits flush
	reg  [NCH-1:0] tx_half_ff, rx_half_ff; // half owned by the serial side
	reg  [5:0]    tx_ptr_ff [0:NCH-1];     // dword within serial half
	reg  [5:0]    rx_ptr_ff [0:NCH-1];
	reg  [4:0]    tx_bit_ff [0:NCH-1];     // bit within dword, lsb first
	reg  [4:0]    rx_bit_ff [0:NCH-1];
	reg  [31:0]   rx_sh_ff  [0:NCH-1];     // receive word assembly
	// link clock sampling and frame position
	reg           lclk_s1_ff, lclk_s2_ff, lclk_s3_ff;
	reg           rxd_s1_ff, rxd_s2_ff;
	reg  [2:0]    bitpos_ff;               // bit within slot
	reg  [SW-1:0] slotpos_ff;              // current slot
	reg           pend_ff;                 // output decision pending
	reg  [1:0]    mode_ff;                 // decided output mode
	reg  [4:0]    bsel_ff;                 // bit to send from ram word
	// dma engine
	reg  [2:0]    d_st_ff;
	reg  [CW-1:0] scan_ff;                 // round-robin service pointer
	reg           d_half_ff;
	reg  [6:0]    d_left_ff;               // dwords left in the job
	reg  [6:0]    d_idx_ff;                // dword within the half
	reg  [5:0]    d_burst_ff;              // dwords left in this burst
	reg           sel_ok, sel_rx, sel_half;
	reg  [1:0]    sel_kind;
	wire [31:0]   tx_rdata, rx_rdata;
	integer       i, j;

	// ahb: zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	wire a_take = hsel & htrans[1] & hready;
	wire wr_go  = a_en_ff & a_wr_ff;
	wire srq_wr = wr_go & (a_addr_ff == `CHFD_SRQ_OFF);
	wire [CW-1:0] srq_ch = hwdata[CW-1:0];
	wire [1:0]    srq_op = hwdata[`CHFD_SRQ_OP_LSB +: 2];

	// read decode of the address phase
	always @* begin
		rd_mux = 32'h0;
		if (haddr[11:8] == `CHFD_CHCFG_WIN && haddr[7] == 1'b0)
			rd_mux = {2'h0, rx_hl_ff[haddr[CW+1:2]], 1'b0, rx_off_ff[haddr[CW+1:2]],
				2'h0, tx_hl_ff[haddr[CW+1:2]], 1'b0, tx_off_ff[haddr[CW+1:2]]};
		else if (haddr[11:8] == `CHFD_SLOT_WIN && haddr[7] == 1'b0)
			rd_mux[7:0] = slot_ff[haddr[SW+1:2]];
		else case (haddr[11:0])
			`CHFD_CTRL_OFF:  rd_mux[3:0] = ctrl_ff;
			`CHFD_TXACT_OFF: rd_mux[NCH-1:0] = tx_act_ff;
			`CHFD_RXACT_OFF: rd_mux[NCH-1:0] = rx_act_ff;
			`CHFD_STAT_OFF: begin
				rd_mux[7:0] = ctrl_ff[`CHFD_CTRL_SUBDIS] ? `CHFD_POOL_FULL
					: `CHFD_POOL_FIXED;
				rd_mux[8] = (d_st_ff != D_IDLE);
			end
			default: rd_mux = 32'h0; // unmapped reads zero
		endcase
	end

	// bus phases and configuration writes
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_en_ff <= 1'b0;
			a_wr_ff <= 1'b0;
			a_addr_ff <= 12'h000;
			hrdata <= 32'h0;
			ctrl_ff <= `CHFD_CTRL_RST;
			for (i = 0; i < NCH; i = i + 1) begin
				tx_off_ff[i] <= 7'h00;
				tx_hl_ff[i] <= 6'h00;
				rx_off_ff[i] <= 7'h00;
				rx_hl_ff[i] <= 6'h00;
			end
			for (i = 0; i < NSLOT; i = i + 1)
				slot_ff[i] <= 8'h00;
		end else begin
			a_en_ff <= a_take;
			a_wr_ff <= hwrite;
			a_addr_ff <= haddr[11:0];
			if (a_take && !hwrite)
				hrdata <= rd_mux;
			if (wr_go) begin
				if (a_addr_ff == `CHFD_CTRL_OFF)
					ctrl_ff <= hwdata[3:0];
				if (a_addr_ff[11:8] == `CHFD_CHCFG_WIN && a_addr_ff[7] == 1'b0) begin
					tx_off_ff[a_addr_ff[CW+1:2]] <= hwdata[`CHFD_CFG_TXOFF +: 7];
					tx_hl_ff[a_addr_ff[CW+1:2]]  <= hwdata[`CHFD_CFG_TXLEN +: 6];
					rx_off_ff[a_addr_ff[CW+1:2]] <= hwdata[`CHFD_CFG_RXOFF +: 7];
					rx_hl_ff[a_addr_ff[CW+1:2]]  <= hwdata[`CHFD_CFG_RXLEN +: 6];
				end
				if (a_addr_ff[11:8] == `CHFD_SLOT_WIN && a_addr_ff[7] == 1'b0)
					slot_ff[a_addr_ff[SW+1:2]] <= hwdata[7:0];
			end
		end
	end

	// bit event: selected edge of the link clock
	wire tx_en  = ctrl_ff[`CHFD_CTRL_TXEN];
	wire subdis = ctrl_ff[`CHFD_CTRL_SUBDIS];
	wire ev = ctrl_ff[`CHFD_CTRL_EDGE] ? (~lclk_s2_ff & lclk_s3_ff)
		: (lclk_s2_ff & ~lclk_s3_ff);
	wire [7:0]    sm     = slot_ff[slotpos_ff];
	wire          mapped = sm[`CHFD_SLOT_MAPPED];
	wire [CW-1:0] sch    = sm[CW-1:0];
	wire tx_ready = tx_act_ff[sch] & ~tx_desc_ff[sch] & ~tx_need_ff[sch][tx_half_ff[sch]];
	wire tx_go  = ev & tx_en & mapped & tx_ready;
	wire rx_go  = ev & mapped & rx_act_ff[sch] & ~rx_desc_ff[sch];
	wire rx_wr  = rx_go & (rx_bit_ff[sch] == 5'h1F);
	wire [31:0] rx_word = {rxd_s2_ff, rx_sh_ff[sch][31:1]};

	// dma handshakes and job completion
	wire [5:0] d_hl    = dma_dir_rx ? rx_hl_ff[dma_chan] : tx_hl_ff[dma_chan];
	wire [6:0] d_start = dma_dir_rx ? rx_off_ff[dma_chan] : tx_off_ff[dma_chan];
	assign dma_req    = (d_st_ff == D_REQ) | (d_st_ff == D_TXB) |
		(d_st_ff == D_RXRD) | (d_st_ff == D_RXW);
	assign dma_rready = (d_st_ff == D_TXB) & ~tx_go; // serial read has the ram
	assign dma_wvalid = (d_st_ff == D_RXW);
	assign dma_wdata  = rx_rdata;
	wire beat_rd  = dma_rready & dma_rvalid;
	wire beat_wr  = dma_wvalid & dma_wready;
	wire beat     = beat_rd | beat_wr;
	wire job_end  = beat & (d_left_ff == 7'h01);
	wire desc_end = job_end & (dma_kind == `CHFD_KIND_DESC);
	wire rd_issue = (d_st_ff == D_RXRD) & ~rx_wr;
	wire [6:0] dma_addr = faddr(d_start, d_half_ff, d_hl, d_idx_ff, subdis);

	// transmit ram: serial reads on bit events, dma fills otherwise
	chfd_mem #(.DW(32), .DEPTH(128), .AW(7)) u_txmem (
		.hclk    (hclk),
		.hresetn (hresetn),
		.en      (tx_go | (beat_rd & (dma_kind == `CHFD_KIND_TXRD))),
		.we      (~tx_go),
		.addr    (tx_go ? faddr(tx_off_ff[sch], tx_half_ff[sch], tx_hl_ff[sch],
			{1'b0, tx_ptr_ff[sch]}, subdis) : dma_addr),
		.wdata   (dma_rdata),
		.rdata   (tx_rdata)
	);

	// receive ram: serial writes whole words, dma reads for flush
	chfd_mem #(.DW(32), .DEPTH(128), .AW(7)) u_rxmem (
		.hclk    (hclk),
		.hresetn (hresetn),
		.en      (rx_wr | rd_issue),
		.we      (rx_wr),
		.addr    (rx_wr ? faddr(rx_off_ff[sch], rx_half_ff[sch], rx_hl_ff[sch],
			{1'b0, rx_ptr_ff[sch]}, subdis) : dma_addr),
		.wdata   (rx_word),
		.rdata   (rx_rdata)
	);

	// service pick under the scan pointer
	always @* begin
		sel_ok = 1'b1;
		sel_rx = 1'b0;
		sel_half = 1'b0;
		sel_kind = `CHFD_KIND_DESC;
		if (tx_desc_ff[scan_ff]) begin
			sel_rx = 1'b0;
		end else if (rx_desc_ff[scan_ff]) begin
			sel_rx = 1'b1;
		end else if (tx_act_ff[scan_ff] && tx_need_ff[scan_ff] != 2'b00) begin
			sel_kind = `CHFD_KIND_TXRD; // serial half first, it starves soonest
			sel_half = tx_need_ff[scan_ff][tx_half_ff[scan_ff]] ? tx_half_ff[scan_ff]
				: ~tx_half_ff[scan_ff];
		end else if (rx_act_ff[scan_ff] && rx_full_ff[scan_ff] != 2'b00) begin
			sel_kind = `CHFD_KIND_RXWR;
			sel_rx = 1'b1;
			sel_half = rx_full_ff[scan_ff][~rx_half_ff[scan_ff]] ? ~rx_half_ff[scan_ff]
				: rx_half_ff[scan_ff];
		end else
			sel_ok = 1'b0;
	end

	// dma sequencer: one job is one half, split into capped bursts
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			d_st_ff <= D_IDLE;
			scan_ff <= {CW{1'b0}};
			d_half_ff <= 1'b0;
			d_left_ff <= 7'h00;
			d_idx_ff <= 7'h00;
			d_burst_ff <= 6'h00;
			dma_kind <= `CHFD_KIND_TXRD;
			dma_dir_rx <= 1'b0;
			dma_chan <= {CW{1'b0}};
			dma_len <= 6'h00;
		end else begin
			case (d_st_ff)
				D_IDLE: begin
					if (sel_ok) begin
						dma_chan <= scan_ff;
						dma_kind <= sel_kind;
						dma_dir_rx <= sel_rx;
						d_half_ff <= sel_half;
						d_idx_ff <= 7'h00;
						d_left_ff <= (sel_kind == `CHFD_KIND_DESC) ? 7'h01
							: ({1'b0, sel_rx ? rx_hl_ff[scan_ff] : tx_hl_ff[scan_ff]} + 7'h01);
						dma_len <= (sel_kind == `CHFD_KIND_DESC) ? 6'h01
							: fburst({1'b0, sel_rx ? rx_hl_ff[scan_ff] : tx_hl_ff[scan_ff]}
							+ 7'h01);
						d_burst_ff <= (sel_kind == `CHFD_KIND_DESC) ? 6'h01
							: fburst({1'b0, sel_rx ? rx_hl_ff[scan_ff] : tx_hl_ff[scan_ff]}
							+ 7'h01);
						d_st_ff <= D_REQ;
					end
					scan_ff <= scan_ff + 1'b1;
				end
				D_REQ: begin
					if (dma_gnt)
						d_st_ff <= (dma_kind == `CHFD_KIND_RXWR) ? D_RXRD : D_TXB;
				end
				D_RXRD: begin
					if (!rx_wr)
						d_st_ff <= D_RXW;
				end
				D_TXB, D_RXW: begin
					if (beat) begin
						d_idx_ff <= d_idx_ff + 7'h01;
						d_left_ff <= d_left_ff - 7'h01;
						d_burst_ff <= d_burst_ff - 6'h01;
						if (job_end)
							d_st_ff <= D_IDLE; // bus released
						else if (d_burst_ff == 6'h01)
							d_st_ff <= D_GAP; // release, then ask again
						else if (d_st_ff == D_RXW)
							d_st_ff <= D_RXRD;
					end
				end
				D_GAP: begin
					dma_len <= fburst(d_left_ff);
					d_burst_ff <= fburst(d_left_ff);
					d_st_ff <= D_REQ;
				end
				default: d_st_ff <= D_IDLE;
			endcase
		end
	end

	// per-channel ping-pong state; serial sets win over dma clears
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_act_ff <= {NCH{1'b0}};
			rx_act_ff <= {NCH{1'b0}};
			tx_desc_ff <= {NCH{1'b0}};
			rx_desc_ff <= {NCH{1'b0}};
			tx_half_ff <= {NCH{1'b0}};
			rx_half_ff <= {NCH{1'b0}};
			for (j = 0; j < NCH; j = j + 1) begin
				tx_need_ff[j] <= 2'b00;
				rx_full_ff[j] <= 2'b00;
				tx_ptr_ff[j] <= 6'h00;
				rx_ptr_ff[j] <= 6'h00;
				tx_bit_ff[j] <= 5'h00;
				rx_bit_ff[j] <= 5'h00;
				rx_sh_ff[j] <= 32'h0;
			end
		end else begin
			// dma completions hand halves back
			if (desc_end && !dma_dir_rx)
				tx_desc_ff[dma_chan] <= 1'b0;
			if (desc_end && dma_dir_rx)
				rx_desc_ff[dma_chan] <= 1'b0;
			if (job_end && dma_kind == `CHFD_KIND_TXRD)
				tx_need_ff[dma_chan][d_half_ff] <= 1'b0;
			if (job_end && dma_kind == `CHFD_KIND_RXWR)
				rx_full_ff[dma_chan][d_half_ff] <= 1'b0;
			// transmit side drains its half bit by bit
			if (tx_go) begin
				tx_bit_ff[sch] <= tx_bit_ff[sch] + 5'h01;
				if (tx_bit_ff[sch] == 5'h1F) begin
					tx_ptr_ff[sch] <= tx_ptr_ff[sch] + 6'h01;
					if (tx_ptr_ff[sch] == tx_hl_ff[sch]) begin
						tx_ptr_ff[sch] <= 6'h00;
						tx_need_ff[sch][tx_half_ff[sch]] <= 1'b1;
						tx_half_ff[sch] <= ~tx_half_ff[sch];
					end
				end
			end
			// receive side assembles words, swaps when full
			if (rx_go) begin
				rx_sh_ff[sch] <= rx_word;
				rx_bit_ff[sch] <= rx_bit_ff[sch] + 5'h01;
				if (rx_wr) begin
					rx_ptr_ff[sch] <= rx_ptr_ff[sch] + 6'h01;
					if (rx_ptr_ff[sch] == rx_hl_ff[sch]) begin
						rx_ptr_ff[sch] <= 6'h00;
						rx_full_ff[sch][rx_half_ff[sch]] <= 1'b1;
						rx_half_ff[sch] <= ~rx_half_ff[sch];
					end
				end
			end
			// activation restarts and queues the fetches
			if (srq_wr) begin
				case (srq_op)
					`CHFD_OP_ACT_TX: begin
						tx_act_ff[srq_ch] <= 1'b1;
						tx_desc_ff[srq_ch] <= 1'b1;
						tx_need_ff[srq_ch] <= 2'b11;
						tx_half_ff[srq_ch] <= 1'b0;
						tx_ptr_ff[srq_ch] <= 6'h00;
						tx_bit_ff[srq_ch] <= 5'h00;
					end
					`CHFD_OP_ACT_RX: begin
						rx_act_ff[srq_ch] <= 1'b1;
						rx_desc_ff[srq_ch] <= 1'b1;
						rx_full_ff[srq_ch] <= 2'b00;
						rx_half_ff[srq_ch] <= 1'b0;
						rx_ptr_ff[srq_ch] <= 6'h00;
						rx_bit_ff[srq_ch] <= 5'h00;
					end
					`CHFD_OP_DEACT: begin
						tx_act_ff[srq_ch] <= 1'b0;
						rx_act_ff[srq_ch] <= 1'b0;
						tx_desc_ff[srq_ch] <= 1'b0;
						rx_desc_ff[srq_ch] <= 1'b0;
						tx_need_ff[srq_ch] <= 2'b00;
						rx_full_ff[srq_ch] <= 2'b00;
					end
					default: ;
				endcase
			end
		end
	end

	// link sampling and the output decision
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lclk_s1_ff <= 1'b0;
			lclk_s2_ff <= 1'b0;
			lclk_s3_ff <= 1'b0;
			rxd_s1_ff <= 1'b0;
			rxd_s2_ff <= 1'b0;
			bitpos_ff <= 3'h0;
			slotpos_ff <= {SW{1'b0}};
			pend_ff <= 1'b0;
			mode_ff <= `CHFD_TXM_Z;
			bsel_ff <= 5'h00;
			serial_tx_data_out <= 1'b1;
			serial_tx_data_oe <= 1'b0;
		end else begin
			lclk_s1_ff <= serial_tx_bit_clock;
			lclk_s2_ff <= lclk_s1_ff;
			lclk_s3_ff <= lclk_s2_ff;
			rxd_s1_ff <= serial_rx_data_in;
			rxd_s2_ff <= rxd_s1_ff;
			pend_ff <= ev;
			if (ev) begin
				bitpos_ff <= bitpos_ff + 3'h1;
				if (bitpos_ff == 3'h7)
					slotpos_ff <= (slotpos_ff == NSLOT - 1) ? {SW{1'b0}}
						: slotpos_ff + 1'b1;
				bsel_ff <= tx_bit_ff[sch];
				if (!tx_en)
					mode_ff <= `CHFD_TXM_Z;
				else if (mapped)
					mode_ff <= tx_ready ? `CHFD_TXM_DATA : `CHFD_TXM_ONE;
				else
					mode_ff <= ctrl_ff[`CHFD_CTRL_TRI] ? `CHFD_TXM_Z
						: `CHFD_TXM_ONE;
			end
			// disable floats the pin at once
			if (!tx_en)
				serial_tx_data_oe <= 1'b0;
			else if (pend_ff) begin
				case (mode_ff)
					`CHFD_TXM_DATA: begin
						serial_tx_data_out <= tx_rdata[bsel_ff];
						serial_tx_data_oe <= 1'b1;
					end
					`CHFD_TXM_ONE: begin
						serial_tx_data_out <= 1'b1;
						serial_tx_data_oe <= 1'b1;
					end
					default: serial_tx_data_oe <= 1'b0;
				endcase
			end
		end
	end
endmodule // chfd_top
